// ===== logic/amcs_sequencer.sv
// Local design decisions: the register addresses and the strobed register port.
`timescale 1ns/1ns
`default_nettype none

module amcs_sequencer (
  input  wire logic                sys_clk,
  input  wire logic                reset_n,
  input  wire logic [15:0]         bus_addr,
  input  wire logic [7:0]          bus_wdata,
  input  wire logic                bus_wr,
  input  wire logic                bus_rd,
  output logic      [7:0]          bus_rdata,
  input  wire logic                slow_sample_clock,
  input  wire logic                sys_power_present,
  input  wire logic                accum_last_next,
  input  wire logic                conv_done,
  input  wire logic [23:0]         conv_data,
  output logic                     conv_start,
  output logic      [3:0]          adc_select,
  output var amcs_pkg::amcs_ram_wr_s ram_wr,
  output logic                     frame_sync_pulse,
  output logic                     ce_pass_start,
  output logic                     chopper_polarity,
  output logic                     chopper_clock,
  output logic                     ref_swap,
  output logic                     cell_load_enable,
  output logic      [9:0]          filter_cycles,
  output logic      [4:0]          result_bits,
  output logic                     alt_frame_active
);

  // ************************************************************
  // Declarations
  // ************************************************************
  logic [7:0]  cfg_q;
  logic [7:0]  cmd_q;
  logic [1:0]  chop_mode_q;
  logic [39:0] reg_sel_q;
  logic [39:0] alt_sel_q;
  logic [7:0]  rd_val;
  logic [7:0]  rdata_q;
  logic        ssc_s1_q;
  logic        ssc_s2_q;
  logic        ssc_s3_q;
  logic        pwr_s1_q;
  logic        pwr_s2_q;
  logic        slow_edge;
  logic        alt_req_prev_q;
  logic        alt_pend_q;
  logic        force_alt_q;
  logic        alt_frame_q;
  logic        chopper_polarity_q;
  logic        sync_q;
  logic        pass_q;
  logic        start_q;
  logic [3:0]  sel_q;
  logic [3:0]  pend_code_q;
  logic        cell_q;
  logic [9:0]  fcyc_q;
  logic [4:0]  rbits_q;
  logic [3:0]  slot_q;
  logic [1:0]  cyc_q;
  logic [3:0]  cnt_raw;
  logic [3:0]  slot_last;
  logic [1:0]  fl_raw;
  logic [1:0]  cyc_last;
  logic        wide;
  logic        frame_begin;
  logic        slot_end;
  logic        frame_end;
  logic        alt_next;
  logic [3:0]  slot_next;
  logic [3:0]  code_next;
  logic        alt_rise;
  logic        cme_eff;
  logic        code_ok;
  logic [23:0] res_mask;
  logic        last_cycle;
  amcs_pkg::amcs_state_e  state_q;
  amcs_pkg::amcs_ram_wr_s ram_q;

  // ************************************************************
  // Register writes
  // ************************************************************
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      cfg_q       <= amcs_pkg::CFG_RST;
      cmd_q       <= amcs_pkg::CMD_RST;
      chop_mode_q <= amcs_pkg::CHOP_RST;
      reg_sel_q   <= amcs_pkg::REG_SEL_RST;
      alt_sel_q   <= amcs_pkg::ALT_SEL_RST;
    end else if (bus_wr) begin
      if (bus_addr == amcs_pkg::ADR_MUX_CFG) begin
        cfg_q <= bus_wdata;
      end
      if (bus_addr == amcs_pkg::ADR_MUX_CMD) begin
        cmd_q <= bus_wdata;
      end
      if (bus_addr == amcs_pkg::ADR_CHOP) begin
        chop_mode_q <= bus_wdata[amcs_pkg::CHOP_LSB+:2];
      end
      for (int i = 0; i < amcs_pkg::SEL_BYTES; i++) begin
        if (bus_addr == amcs_pkg::ADR_REG_SEL + 16'(i)) begin
          reg_sel_q[i*8+:8] <= bus_wdata;
        end
        if (bus_addr == amcs_pkg::ADR_ALT_SEL + 16'(i)) begin
          alt_sel_q[i*8+:8] <= bus_wdata;
        end
      end
    end
  end

  // ************************************************************
  // Register reads
  // ************************************************************
  always_comb begin
    rd_val = 8'h00;
    case (bus_addr)
      amcs_pkg::ADR_MUX_CFG: rd_val = cfg_q;
      amcs_pkg::ADR_MUX_CMD: rd_val = cmd_q;
      amcs_pkg::ADR_CHOP: begin
        rd_val[amcs_pkg::CHOP_LSB+:2] = chop_mode_q;
      end
      amcs_pkg::ADR_STATUS: begin
        rd_val = {4'h0, alt_pend_q, sync_q, alt_frame_q, chopper_polarity_q};
      end
      default: rd_val = 8'h00;
    endcase
    for (int i = 0; i < amcs_pkg::SEL_BYTES; i++) begin
      if (bus_addr == amcs_pkg::ADR_REG_SEL + 16'(i)) begin
        rd_val = reg_sel_q[i*8+:8];
      end
      if (bus_addr == amcs_pkg::ADR_ALT_SEL + 16'(i)) begin
        rd_val = alt_sel_q[i*8+:8];
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      rdata_q <= 8'h00;
    end else if (bus_rd) begin
      rdata_q <= rd_val;
    end else begin
      rdata_q <= 8'h00;
    end
  end

  assign bus_rdata = rdata_q;

  // ************************************************************
  // Pin synchronisers
  // ************************************************************
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      ssc_s1_q <= 1'b0;
      ssc_s2_q <= 1'b0;
      ssc_s3_q <= 1'b0;
      pwr_s1_q <= 1'b0;
      pwr_s2_q <= 1'b0;
    end else begin
      ssc_s1_q <= slow_sample_clock;
      ssc_s2_q <= ssc_s1_q;
      ssc_s3_q <= ssc_s2_q;
      pwr_s1_q <= sys_power_present;
      pwr_s2_q <= pwr_s1_q;
    end
  end

  assign slow_edge = ssc_s2_q & ~ssc_s3_q;

  // ************************************************************
  // Frame geometry
  // ************************************************************
  always_comb begin
    cnt_raw = cfg_q[amcs_pkg::CFG_CNT_LSB+:4];
    if (cnt_raw == 4'h0) begin
      slot_last = 4'h0;
    end else if (cnt_raw > 4'(amcs_pkg::MAX_SLOTS)) begin
      slot_last = 4'(amcs_pkg::MAX_SLOTS - 1);
    end else begin
      slot_last = cnt_raw - 4'h1;
    end
    fl_raw = cfg_q[amcs_pkg::CFG_FL_LSB+:2];
    if (fl_raw > amcs_pkg::FL_LONGEST) begin
      cyc_last = amcs_pkg::FL_LONGEST;
    end else begin
      cyc_last = fl_raw;
    end
  end

  assign wide = {cfg_q[amcs_pkg::CFG_CKHI_BIT],
                 cfg_q[amcs_pkg::CFG_CKLO_BIT]} == amcs_pkg::CLK_PAIR_WIDE;

  assign last_cycle  = cyc_q == cyc_last;
  assign frame_begin = slow_edge && (state_q != amcs_pkg::ST_CONV);
  assign slot_end    = slow_edge && (state_q == amcs_pkg::ST_CONV)
                       && last_cycle;
  assign frame_end   = slot_end && (slot_q >= slot_last);
  assign alt_next    = frame_begin ? (alt_pend_q | force_alt_q)
                                   : alt_frame_q;
  assign slot_next   = frame_begin ? 4'h0 : slot_q + 4'h1;
  assign code_next   = alt_next ? alt_sel_q[{slot_next, 2'b00}+:4]
                                : reg_sel_q[{slot_next, 2'b00}+:4];

  // ************************************************************
  // Slot and state sequencing
  // ************************************************************
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      state_q     <= amcs_pkg::ST_WAIT;
      slot_q      <= 4'h0;
      cyc_q       <= 2'h0;
      alt_frame_q <= 1'b0;
    end else if (slow_edge) begin
      case (state_q)
        amcs_pkg::ST_WAIT, amcs_pkg::ST_SETTLE: begin
          state_q     <= amcs_pkg::ST_CONV;
          slot_q      <= 4'h0;
          cyc_q       <= 2'h0;
          alt_frame_q <= alt_next;
        end
        amcs_pkg::ST_CONV: begin
          if (last_cycle) begin
            cyc_q <= 2'h0;
            if (frame_end) begin
              state_q <= amcs_pkg::ST_SETTLE;
            end else begin
              slot_q <= slot_next;
            end
          end else begin
            cyc_q <= cyc_q + 2'h1;
          end
        end
        default: state_q <= amcs_pkg::ST_WAIT;
      endcase
    end
  end

  // ************************************************************
  // Conversion start and input select
  // ************************************************************
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      start_q     <= 1'b0;
      sel_q       <= 4'h0;
      pend_code_q <= 4'h0;
    end else begin
      start_q <= frame_begin || (slot_end && !frame_end);
      if (frame_begin || (slot_end && !frame_end)) begin
        sel_q       <= code_next;
        pend_code_q <= code_next;
      end
    end
  end

  assign conv_start       = start_q;
  assign adc_select       = sel_q;
  assign alt_frame_active = alt_frame_q;

  // ************************************************************
  // Alternate frame request
  // ************************************************************
  assign alt_rise = cmd_q[amcs_pkg::CMD_ALT_BIT] & ~alt_req_prev_q;

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      alt_req_prev_q <= 1'b0;
      alt_pend_q     <= 1'b0;
    end else begin
      alt_req_prev_q <= cmd_q[amcs_pkg::CMD_ALT_BIT];
      if (alt_rise) begin
        alt_pend_q <= 1'b1;
      end else if (frame_begin) begin
        alt_pend_q <= 1'b0;
      end
    end
  end

  // ************************************************************
  // Chopper and frame sync
  // ************************************************************
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      chopper_polarity_q     <= 1'b0;
      force_alt_q <= 1'b0;
      sync_q      <= 1'b0;
      pass_q      <= 1'b0;
    end else begin
      pass_q <= frame_end;
      if (frame_end) begin
        sync_q <= 1'b1;
        force_alt_q <= 1'b0;
        case (chop_mode_q)
          amcs_pkg::CHOP_FIX_LOW:  chopper_polarity_q <= 1'b0;
          amcs_pkg::CHOP_FIX_HIGH: chopper_polarity_q <= 1'b1;
          amcs_pkg::CHOP_TOGGLE_ACC: begin
            if (accum_last_next) begin
              force_alt_q <= 1'b1;
            end else begin
              chopper_polarity_q <= ~chopper_polarity_q;
            end
          end
          amcs_pkg::CHOP_TOGGLE_ALL: chopper_polarity_q <= ~chopper_polarity_q;
          default: chopper_polarity_q <= chopper_polarity_q;
        endcase
      end else if (frame_begin) begin
        sync_q <= 1'b0;
        if (state_q == amcs_pkg::ST_SETTLE) begin
          force_alt_q <= 1'b0;
        end
      end
    end
  end

  assign frame_sync_pulse = sync_q;
  assign ce_pass_start    = pass_q;
  assign chopper_polarity = chopper_polarity_q;
  assign chopper_clock    = chopper_polarity_q;
  assign ref_swap         = chopper_polarity_q;

  // ************************************************************
  // Resolution and result store
  // ************************************************************
  assign cme_eff = cmd_q[amcs_pkg::CMD_CME_BIT] & pwr_s2_q;

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      fcyc_q  <= 10'h000;
      rbits_q <= 5'h00;
      cell_q  <= 1'b0;
    end else begin
      fcyc_q  <= wide ? amcs_pkg::FIR_CYC_WID[cyc_last]
                      : amcs_pkg::FIR_CYC_STD[cyc_last];
      rbits_q <= wide ? amcs_pkg::FIR_RES_WID[cyc_last]
                      : amcs_pkg::FIR_RES_STD[cyc_last];
      cell_q  <= cme_eff && alt_frame_q;
    end
  end

  assign filter_cycles    = fcyc_q;
  assign result_bits      = rbits_q;
  assign cell_load_enable = cell_q;

  assign res_mask = ~(24'hFF_FFFF << rbits_q);
  assign code_ok  = (pend_code_q <= amcs_pkg::SIG_LAST_MAIN)
                    || (pend_code_q == amcs_pkg::SIG_HEAT)
                    || ((pend_code_q == amcs_pkg::SIG_CELL) && cme_eff);

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      ram_q <= '0;
    end else begin
      ram_q.we   <= conv_done && code_ok;
      ram_q.addr <= {{(amcs_pkg::RAM_AW - 4){1'b0}}, pend_code_q};
      ram_q.data <= 32'(conv_data & res_mask)
                    << amcs_pkg::RESULT_SHIFT;
    end
  end

  assign ram_wr = ram_q;

  // ************************************************************
  // Checks
  // ************************************************************
  a_conv_on_edge: assert property (@(posedge sys_clk) disable iff (!reset_n)
    $rose(conv_start) |-> $past(slow_edge))
    else $error("conversion start not on slow edge");

  a_sync_rise_edge: assert property (@(posedge sys_clk)
    disable iff (!reset_n)
    $rose(frame_sync_pulse) |-> $past(slow_edge) && ce_pass_start
    ##1 !ce_pass_start)
    else $error("frame sync rise without pass start");

  a_sync_fall_edge: assert property (@(posedge sys_clk)
    disable iff (!reset_n)
    $fell(frame_sync_pulse) |-> $past(slow_edge) && conv_start)
    else $error("settle cycle ended off edge");

  a_fixed_low: assert property (@(posedge sys_clk) disable iff (!reset_n)
    $rose(frame_sync_pulse) && $past(chop_mode_q) == 2'b01
    |-> !chopper_polarity && !chopper_clock)
    else $error("fixed low mode left polarity high");

  a_toggle_all: assert property (@(posedge sys_clk) disable iff (!reset_n)
    $rose(frame_sync_pulse) && $past(chop_mode_q) == 2'b11
    |-> chopper_polarity != $past(chopper_polarity))
    else $error("mode 11 failed to toggle");

  a_skip_toggle: assert property (@(posedge sys_clk) disable iff (!reset_n)
    $rose(frame_sync_pulse) && $past(chop_mode_q) == 2'b00
    && $past(accum_last_next)
    |-> $stable(chopper_polarity) && force_alt_q)
    else $error("toggle not skipped before forced frame");

  a_cell_gate: assert property (@(posedge sys_clk) disable iff (!reset_n)
    $past(!pwr_s2_q) |-> !cell_load_enable)
    else $error("cell load without system power");

  a_ram_shift: assert property (@(posedge sys_clk) disable iff (!reset_n)
    ram_wr.we |-> ram_wr.data[7:0] == 8'h00
    && ram_wr.data[31:8] == ($past(conv_data) & $past(res_mask)))
    else $error("result not shifted by eight");

  a_ram_addr: assert property (@(posedge sys_clk) disable iff (!reset_n)
    ram_wr.we |-> ram_wr.addr <= 10'h006 || ram_wr.addr == 10'h00A
    || ram_wr.addr == 10'h00B)
    else $error("result word out of map");

endmodule

`default_nettype wire

// ===== logic/amcs_pkg.sv
// ************************************************************
// Sequencer constants and types
// ************************************************************
package amcs_pkg;

  localparam int ADDR_W    = 16;
  localparam int DATA_W    = 8;
  localparam int RAM_AW    = 10;
  localparam int MAX_SLOTS = 10;
  localparam int SEL_BYTES = 5;

  // ************************************************************
  // Register offsets
  // ************************************************************
  localparam logic [15:0] ADR_MUX_CFG = 16'h2000;
  localparam logic [15:0] ADR_MUX_CMD = 16'h2001;
  localparam logic [15:0] ADR_CHOP    = 16'h2002;
  localparam logic [15:0] ADR_STATUS  = 16'h2003;
  localparam logic [15:0] ADR_REG_SEL = 16'h2010;
  localparam logic [15:0] ADR_ALT_SEL = 16'h2015;

  // ************************************************************
  // Field positions
  // ************************************************************
  localparam int CFG_CNT_LSB  = 0;
  localparam int CFG_FL_LSB   = 4;
  localparam int CFG_CKLO_BIT = 6;
  localparam int CFG_CKHI_BIT = 7;
  localparam int CMD_ALT_BIT  = 0;
  localparam int CMD_CME_BIT  = 6;
  localparam int CHOP_LSB     = 4;

  // ************************************************************
  // Reset values
  // ************************************************************
  localparam logic [7:0]  CFG_RST     = 8'h07;
  localparam logic [7:0]  CMD_RST     = 8'h00;
  localparam logic [1:0]  CHOP_RST    = 2'h0;
  localparam logic [39:0] REG_SEL_RST = 40'h00_0654_3210;
  localparam logic [39:0] ALT_SEL_RST = 40'h00_0654_3B1A;

  // ************************************************************
  // Signal codes and result placement
  // ************************************************************
  localparam logic [3:0] SIG_LAST_MAIN = 4'h6;
  localparam logic [3:0] SIG_HEAT      = 4'hA;
  localparam logic [3:0] SIG_CELL      = 4'hB;
  localparam int         RESULT_SHIFT  = 8;

  // ************************************************************
  // Filter length tables
  // ************************************************************
  localparam logic [9:0] FIR_CYC_STD [0:2] = '{10'h08A, 10'h120, 10'h180};
  localparam logic [9:0] FIR_CYC_WID [0:2] = '{10'h0BA, 10'h180, 10'h24C};
  localparam logic [4:0] FIR_RES_STD [0:2] = '{5'h12, 5'h15, 5'h16};
  localparam logic [4:0] FIR_RES_WID [0:2] = '{5'h13, 5'h16, 5'h18};
  localparam logic [1:0] CLK_PAIR_WIDE = 2'h1;
  localparam logic [1:0] FL_LONGEST    = 2'h2;

  typedef enum logic [1:0] {
    CHOP_TOGGLE_ACC = 2'b00,
    CHOP_FIX_LOW    = 2'b01,
    CHOP_FIX_HIGH   = 2'b10,
    CHOP_TOGGLE_ALL = 2'b11
  } amcs_chop_mode;

  typedef enum logic [1:0] {
    ST_WAIT   = 2'b00,
    ST_CONV   = 2'b01,
    ST_SETTLE = 2'b10
  } amcs_state_e;

  typedef struct packed {
    logic              we;
    logic [RAM_AW-1:0] addr;
    logic [31:0]       data;
  } amcs_ram_wr_s;

endpackage

// ===== test/amcs_filter_model.sv
`timescale 1ns/1ns
`default_nettype none

// ************************************************************
// Filter stand-in: answers each conversion start
// ************************************************************
module amcs_filter_model #(
  parameter int DELAY = 10
) (
  input  wire logic        sys_clk,
  input  wire logic        reset_n,
  input  wire logic        conv_start,
  output logic             conv_done,
  output logic      [23:0] conv_data
);
  int   cnt_q;
  logic wig_q;

  // Done only after a commanded start
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      cnt_q     <= 0;
      conv_done <= 1'b0;
    end else begin
      conv_done <= (cnt_q == 1);
      if (conv_start) begin
        cnt_q <= DELAY;
      end else if (cnt_q != 0) begin
        cnt_q <= cnt_q - 1;
      end
    end
  end

  // Data lines churn outside the valid cycle
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      wig_q <= 1'b0;
    end else begin
      wig_q <= ~wig_q;
    end
  end
  assign conv_data = conv_done ? 24'hff_ffff : {12{wig_q, ~wig_q}};
endmodule

`default_nettype wire

// ===== test/amcs_sequencer_bench.sv
`timescale 1ns/1ns
`default_nettype none

module amcs_sequencer_bench;
  logic        sys_clk = 0, reset_n = 0, bus_wr = 0, bus_rd = 0;
  logic        slow = 0, slow_en = 0, pwr = 1, accum = 0;
  logic [15:0] bus_addr = '0;
  logic [7:0]  bus_wdata = '0, bus_rdata;
  logic        conv_done, conv_start, frame_sync_pulse, ce_pass_start;
  logic        chopper_polarity, chopper_clock, ref_swap;
  logic        cell_load_enable, alt_frame_active;
  logic [23:0] conv_data;
  logic [3:0]  adc_select;
  logic [9:0]  filter_cycles;
  logic [4:0]  result_bits;
  logic [3:0]  codes[$];
  amcs_pkg::amcs_ram_wr_s ram_wr;
  int          n_mismatch = 0, n_tests = 0, exp_bits = 18, n_cell = 0;
  int          slow_cnt = 0, gap = 0, last_gap = 0, sync_len = 0;
  int          sync_run = 0;
  logic        pol_q = 0;

  always #5 sys_clk = ~sys_clk;

  amcs_sequencer dut_u (.sys_clk(sys_clk), .reset_n(reset_n),
    .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr),
    .bus_rd(bus_rd), .bus_rdata(bus_rdata), .slow_sample_clock(slow),
    .sys_power_present(pwr), .accum_last_next(accum),
    .conv_done(conv_done), .conv_data(conv_data),
    .conv_start(conv_start), .adc_select(adc_select), .ram_wr(ram_wr),
    .frame_sync_pulse(frame_sync_pulse), .ce_pass_start(ce_pass_start),
    .chopper_polarity(chopper_polarity), .chopper_clock(chopper_clock),
    .ref_swap(ref_swap), .cell_load_enable(cell_load_enable),
    .filter_cycles(filter_cycles), .result_bits(result_bits),
    .alt_frame_active(alt_frame_active));

  amcs_filter_model #(.DELAY(10)) filt_u (.sys_clk(sys_clk),
    .reset_n(reset_n), .conv_start(conv_start), .conv_done(conv_done),
    .conv_data(conv_data));

  // ************************************************************
  // Helpers
  // ************************************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t seen %h exp %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    bus_wr    <= 1'b1;
    bus_addr  <= a;
    bus_wdata <= d;
    @(posedge sys_clk);
    bus_wr <= 1'b0;
  endtask

  task automatic rd_chk(input logic [15:0] a, input logic [7:0] e);
    @(posedge sys_clk);
    bus_rd   <= 1'b1;
    bus_addr <= a;
    @(posedge sys_clk);
    bus_rd <= 1'b0;
    #1;
    check(bus_rdata, e);
  endtask

  task automatic wait_on(input bit conv, input int n);
    int k;
    repeat (n) begin
      k = 0;
      do begin
        @(posedge sys_clk);
        #1;
        k++;
      end while (!(conv ? conv_start : ce_pass_start) && k < 2000);
      check(k < 2000, 1);
    end
  endtask

  // Slow clock: 40 system cycles a period
  always @(posedge sys_clk) begin
    if (slow_en && slow_cnt == 19) begin
      slow     <= ~slow;
      slow_cnt <= 0;
    end else if (slow_en) begin
      slow_cnt <= slow_cnt + 1;
    end
  end

  // Watches results, chopper and sync
  always @(posedge sys_clk) begin
    if (reset_n) begin
      gap <= gap + 1;
      if (conv_start) begin
        codes.push_back(adc_select);
        last_gap <= gap;
        gap      <= 1;
      end
      if (frame_sync_pulse) begin
        sync_len <= sync_len + 1;
      end else if (sync_len != 0) begin
        sync_run <= sync_len;
        sync_len <= 0;
      end
      if (ram_wr.we) begin
        check(ram_wr.data, ((32'h1 << exp_bits) - 1) << 8);
        check(ram_wr.addr, {6'h00, codes[$]});
        if (ram_wr.addr == 10'h00b) n_cell++;
      end
      if (chopper_polarity !== pol_q) check(ce_pass_start, 1);
      pol_q <= chopper_polarity;
      if (ce_pass_start) begin
        check(frame_sync_pulse, 1);
        check({chopper_clock, ref_swap}, {2{chopper_polarity}});
      end
    end
  end

  // ************************************************************
  // Scenarios
  // ************************************************************
  task automatic t_reset;
    check({filter_cycles, result_bits}, {10'h08a, 5'h12});
    rd_chk(amcs_pkg::ADR_MUX_CFG, 8'h07);
    rd_chk(amcs_pkg::ADR_MUX_CMD, 8'h00);
    rd_chk(amcs_pkg::ADR_CHOP, 8'h00);
    for (int i = 0; i < 3; i++) begin
      rd_chk(amcs_pkg::ADR_REG_SEL + 16'(i), 8'h10 + 8'h22 * i[7:0]);
    end
    rd_chk(amcs_pkg::ADR_REG_SEL + 3, 8'h06);
    rd_chk(amcs_pkg::ADR_ALT_SEL, 8'h1a);
    rd_chk(amcs_pkg::ADR_ALT_SEL + 1, 8'h3b);
    rd_chk(16'h2100, 8'h00);
  endtask

  task automatic t_filter;
    logic [14:0] nrm [0:2] = '{{10'h08a, 5'h12}, {10'h120, 5'h15},
                               {10'h180, 5'h16}};
    logic [14:0] wid [0:2] = '{{10'h0ba, 5'h13}, {10'h180, 5'h16},
                               {10'h24c, 5'h18}};
    for (int p = 0; p < 4; p++) begin
      for (int f = 0; f < 3; f++) begin
        wr(amcs_pkg::ADR_MUX_CFG, {p[1:0], f[1:0], 4'h7});
        repeat (3) @(posedge sys_clk);
        check({filter_cycles, result_bits}, p == 1 ? wid[f] : nrm[f]);
      end
    end
    wr(amcs_pkg::ADR_MUX_CFG, 8'h07);
  endtask

  task automatic t_regular;
    wait_on(0, 2);
    codes.delete();
    wait_on(0, 1);
    check(codes.size(), 7);
    for (int i = 0; i < 7; i++) check(codes[i], i);
    check(sync_run, 40);
    check(last_gap, 40);
  endtask

  task automatic t_slots(input logic [7:0] cfg, input int n, input int g);
    wr(amcs_pkg::ADR_MUX_CFG, cfg);
    exp_bits = (cfg[5:4] == 2'h0) ? 18 : 22;
    wait_on(0, 2);
    codes.delete();
    wait_on(0, 1);
    check(codes.size(), n);
    if (n > 1) check(last_gap, g);
  endtask

  task automatic t_chop;
    logic p;
    wr(amcs_pkg::ADR_CHOP, 8'h10);
    wait_on(0, 1);
    check(chopper_polarity, 0);
    wr(amcs_pkg::ADR_CHOP, 8'h20);
    wait_on(0, 1);
    check(chopper_polarity, 1);
    rd_chk(amcs_pkg::ADR_STATUS, 8'h05);
    accum <= 1'b1;
    wr(amcs_pkg::ADR_CHOP, 8'h30);
    wait_on(0, 1);
    p = chopper_polarity;
    wait_on(0, 1);
    check(chopper_polarity, !p);
    wait_on(1, 1);
    check(alt_frame_active, 0);
    accum <= 1'b0;
    wr(amcs_pkg::ADR_CHOP, 8'h00);
    wait_on(0, 1);
    p = chopper_polarity;
    accum <= 1'b1;
    wait_on(0, 1);
    check(chopper_polarity, p);
    accum <= 1'b0;
    wait_on(1, 1);
    check(alt_frame_active, 1);
    wait_on(0, 1);
    check(chopper_polarity, !p);
  endtask

  task automatic t_alt(input logic pw);
    int n0;
    wait_on(0, 1);
    pwr <= pw;
    wr(amcs_pkg::ADR_MUX_CMD, 8'h40);
    wr(amcs_pkg::ADR_MUX_CMD, 8'h41);
    wr(amcs_pkg::ADR_MUX_CMD, 8'h40);
    n0 = n_cell;
    codes.delete();
    wait_on(1, 1);
    check(alt_frame_active, 1);
    @(posedge sys_clk);
    #1;
    check(cell_load_enable, pw);
    wait_on(0, 1);
    check({codes[0], codes[2]}, {4'ha, 4'hb});
    check(n_cell - n0, pw);
    wait_on(1, 1);
    check(alt_frame_active, 0);
  endtask

  task automatic results;
    $display("tests %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (3) @(posedge sys_clk);
    reset_n <= 1'b1;
    @(posedge sys_clk);
    #1;
    t_reset();
    t_filter();
    slow_en <= 1'b1;
    t_regular();
    t_slots(8'h23, 3, 120);
    t_slots(8'h00, 1, 0);
    t_slots(8'h0f, 10, 40);
    t_slots(8'h07, 7, 40);
    t_chop();
    t_alt(1'b1);
    t_alt(1'b0);
    results();
  end

  initial begin
    repeat (60000) @(posedge sys_clk);
    n_mismatch++;
    results();
  end
endmodule

`default_nettype wire
